// file: rtl/mccrt_pkg.sv
// Constants shared by the main clock, time base and tone unit
package mccrt_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_CLOCK_CONTROL_STATUS = 8'h2C;
  localparam logic [7:0] IDX_TONE_CONTROL_REG     = 8'h2D;
  localparam logic [7:0] IDX_EVENT_STATUS         = 8'h2E;
  localparam logic [7:0] IDX_EVENT_MASK           = 8'h2F;
  localparam logic [7:0] IDX_POWER_STATE          = 8'h30;

  // ==========================================================
  // Field positions in clock_control_status
  localparam int POS_CLOCK_OUT_SELECT    = 7;
  localparam int POS_CPU_DIVIDER_SELECT  = 5;
  localparam int POS_SLOW_MODE_SELECT    = 4;
  localparam int POS_TIME_BASE_SELECT    = 2;
  localparam int POS_TICK_IRQ_ENABLE     = 1;
  localparam int POS_TICK_IRQ_FLAG       = 0;

  // Event status bit positions
  localparam int POS_EV_TICK             = 0;
  localparam int POS_EV_WAKE             = 1;
  localparam int NUM_EVENTS              = 2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_CLOCK_CONTROL_STATUS = 8'h00;
  localparam logic [1:0] RST_TONE_SELECT          = 2'h0;
  localparam logic [1:0] RST_EVENT_MASK           = 2'h0;

  // ==========================================================
  // Time base periods in oscillator clock cycles
  localparam int TB_PERIOD_0 = 16000;
  localparam int TB_PERIOD_1 = 32000;
  localparam int TB_PERIOD_2 = 80000;
  localparam int TB_PERIOD_3 = 200000;

  // Tone half periods, from the tone frequency at an 8 MHz oscillator
  localparam int OSC_FREQ_HZ   = 8000000;
  localparam int TONE_HZ_1     = 2000;
  localparam int TONE_HZ_2     = 1000;
  localparam int TONE_HZ_3     = 500;
  localparam int TONE_HALF_1   = OSC_FREQ_HZ / (2 * TONE_HZ_1);
  localparam int TONE_HALF_2   = OSC_FREQ_HZ / (2 * TONE_HZ_2);
  localparam int TONE_HALF_3   = OSC_FREQ_HZ / (2 * TONE_HZ_3);

  // ==========================================================
  // Power states, one-hot
  typedef enum logic [3:0] {
    PWR_RUN   = 4'b0001,
    PWR_WAIT  = 4'b0010,
    PWR_AHALT = 4'b0100,
    PWR_HALT  = 4'b1000
  } mccrt_pwr_e;

endpackage

// file: rtl/mccrt_top.sv
// Main clock unit: CPU clock divider, clock out, time base and tone
//
// How it works
// - slow mode off gives full oscillator rate
// - slow mode divides by 2, 4, 8, 16
// - clock out select drives the pin
// - clock out suspended in active halt
// - time base periods 16000 to 200000 cycles
// - new time base applies after current period
// - period end sets the tick flag
// - status register read clears the tick flag
// - tick request needs flag, enable, no mask
// - halt with tick enable enters active halt
// - active halt counts, freezes registers, tick wakes
// - halt freezes all; only other source wakes
// - wait leaves unit running; tick wakes
// - tone output with three selectable frequencies
// - tone codes off, 2k, 1k, 500 Hz
// - control status register resets to zero
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module mccrt_top #(
  parameter int TB_CYC_0   = mccrt_pkg::TB_PERIOD_0,
  parameter int TB_CYC_1   = mccrt_pkg::TB_PERIOD_1,
  parameter int TB_CYC_2   = mccrt_pkg::TB_PERIOD_2,
  parameter int TB_CYC_3   = mccrt_pkg::TB_PERIOD_3,
  parameter int TONE_CYC_1 = mccrt_pkg::TONE_HALF_1,
  parameter int TONE_CYC_2 = mccrt_pkg::TONE_HALF_2,
  parameter int TONE_CYC_3 = mccrt_pkg::TONE_HALF_3
) (
  // Clock and reset
  input  wire logic        I_MCLK,
  input  wire logic        I_RESET_N,
  // AHB-Lite slave
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic      [31:0] O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP,
  // CPU core power control
  input  wire logic        I_WAIT_REQ,
  input  wire logic        I_HALT_REQ,
  input  wire logic        I_EXT_WAKE,
  input  wire logic        I_GLOBAL_MASK,
  output logic      [3:0]  O_PWR_STATE,
  output logic             O_WAKE,
  // Divided CPU clock as an enable on the oscillator clock
  output logic             O_CPU_CLK_EN,
  // Clock out and tone pins
  output logic             O_CLK_OUT,
  output logic             O_CLK_OUT_OE_N,
  output logic             O_TONE,
  output logic             O_TONE_OE_N,
  // Interrupts
  output logic             O_TICK_IRQ_REQ,
  output logic             O_IRQ
);
  import mccrt_pkg::*;

  // ==========================================================
  // Helpers

  // True when a byte address hits a register index
  function automatic logic idx_hit(input logic [31:0] a,
                                   input logic [7:0]  idx);
    idx_hit = (a[31:2] == {22'h000000, idx});
  endfunction

  // Time base period minus one for a select code
  function automatic logic [17:0] tb_last(input logic [1:0] s);
    case (s)
      2'h0:    tb_last = 18'(TB_CYC_0 - 1);
      2'h1:    tb_last = 18'(TB_CYC_1 - 1);
      2'h2:    tb_last = 18'(TB_CYC_2 - 1);
      default: tb_last = 18'(TB_CYC_3 - 1);
    endcase
  endfunction

  // ==========================================================
  // State

  logic [7:0]  ccs_q;            // Control status register
  logic [7:0]  ccs_d;
  logic [1:0]  tone_sel_q;       // Tone select
  logic [1:0]  ev_status_q;      // Sticky events
  logic [1:0]  ev_status_d;
  logic [1:0]  ev_mask_q;        // Event mask
  mccrt_pwr_e  pwr_q;            // Power state
  mccrt_pwr_e  pwr_d;
  logic [17:0] tb_cnt_q;         // Time base counter
  logic [1:0]  tb_act_q;         // Time base select in force
  logic [3:0]  div_cnt_q;        // CPU clock divider
  logic [13:0] tone_cnt_q;       // Tone half period counter
  logic        tone_q;           // Tone level
  logic        clk_out_q;        // Clock out level
  logic        clk_out_oe_n_q;   // Clock out enable
  logic        tone_oe_n_q;      // Tone enable
  logic        wake_q;           // Wake pulse
  logic [31:0] hrdata_q;         // Read data
  logic        wr_pend_q;        // Write data phase pending
  logic [7:0]  wr_idx_q;         // Write target index

  // ==========================================================
  // Bus decode

  wire         acc      = I_HSEL & I_HTRANS[1] & I_HREADY;
  wire         rd_acc   = acc & ~I_HWRITE;
  wire         wr_acc   = acc & I_HWRITE;
  wire         rd_ccs   = rd_acc & idx_hit(I_HADDR, IDX_CLOCK_CONTROL_STATUS);
  wire         frozen   = (pwr_q == PWR_AHALT) | (pwr_q == PWR_HALT);
  wire         wr_en    = wr_pend_q & ~frozen;
  wire         wr_ccs   = wr_en & (wr_idx_q == IDX_CLOCK_CONTROL_STATUS);
  wire         wr_tone  = wr_en & (wr_idx_q == IDX_TONE_CONTROL_REG);
  wire         wr_evs   = wr_en & (wr_idx_q == IDX_EVENT_STATUS);
  wire         wr_evm   = wr_en & (wr_idx_q == IDX_EVENT_MASK);

  // Field views
  wire         clock_out_select      = ccs_q[POS_CLOCK_OUT_SELECT];
  wire [1:0]   cp_sel   = ccs_q[POS_CPU_DIVIDER_SELECT +: 2];
  wire         slow_mode_select      = ccs_q[POS_SLOW_MODE_SELECT];
  wire [1:0]   tb_sel   = ccs_q[POS_TIME_BASE_SELECT +: 2];
  wire         tick_ie  = ccs_q[POS_TICK_IRQ_ENABLE];
  wire         tick_fl  = ccs_q[POS_TICK_IRQ_FLAG];

  // Read mux
  wire [31:0]  rd_val =
      idx_hit(I_HADDR, IDX_CLOCK_CONTROL_STATUS) ? {24'h000000, ccs_q} :
      idx_hit(I_HADDR, IDX_TONE_CONTROL_REG) ? {30'h0, tone_sel_q} :
      idx_hit(I_HADDR, IDX_EVENT_STATUS)     ? {30'h0, ev_status_q} :
      idx_hit(I_HADDR, IDX_EVENT_MASK)       ? {30'h0, ev_mask_q} :
      idx_hit(I_HADDR, IDX_POWER_STATE)      ? {28'h0, pwr_q} :
      32'h00000000;

  // ==========================================================
  // Time base

  wire         tb_run   = (pwr_q != PWR_HALT);
  wire         tb_end   = tb_run & (tb_cnt_q == tb_last(tb_act_q));

  // Counter and select in force; the new select waits for the period end
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      tb_cnt_q <= 18'h00000;
      tb_act_q <= 2'h0;
    end else if (tb_end) begin
      tb_cnt_q <= 18'h00000;
      tb_act_q <= tb_sel;
    end else if (tb_run) begin
      tb_cnt_q <= tb_cnt_q + 18'h00001;
    end
  end

  // ==========================================================
  // Control status register

  // Software writes all bits but the flag; reads clear the flag
  always_comb begin
    ccs_d = ccs_q;
    if (wr_ccs) begin
      ccs_d[7:1] = I_HWDATA[7:1];
    end
    if (rd_ccs) begin
      ccs_d[POS_TICK_IRQ_FLAG] = 1'b0;
    end
    if (tb_end) begin
      ccs_d[POS_TICK_IRQ_FLAG] = 1'b1;
    end
  end

  // Register update
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ccs_q <= RST_CLOCK_CONTROL_STATUS;
    end else begin
      ccs_q <= ccs_d;
    end
  end

  // Tone select and event mask
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      tone_sel_q <= RST_TONE_SELECT;
      ev_mask_q  <= RST_EVENT_MASK;
    end else begin
      if (wr_tone) begin
        tone_sel_q <= I_HWDATA[1:0];
      end
      if (wr_evm) begin
        ev_mask_q <= I_HWDATA[1:0];
      end
    end
  end

  // ==========================================================
  // Power state

  wire         tick_req = tick_fl & tick_ie & ~I_GLOBAL_MASK;

  // Halt choice, wake sources per state
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      PWR_RUN: begin
        if (I_HALT_REQ) begin
          pwr_d = tick_ie ? PWR_AHALT : PWR_HALT;
        end else if (I_WAIT_REQ) begin
          pwr_d = PWR_WAIT;
        end
      end
      PWR_WAIT: begin
        if (tick_req | I_EXT_WAKE) begin
          pwr_d = PWR_RUN;
        end
      end
      PWR_AHALT: begin
        if (tick_req | I_EXT_WAKE) begin
          pwr_d = PWR_RUN;
        end
      end
      PWR_HALT: begin
        if (I_EXT_WAKE) begin
          pwr_d = PWR_RUN;
        end
      end
      default: pwr_d = PWR_RUN;
    endcase
  end

  // State and wake pulse
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      pwr_q  <= PWR_RUN;
      wake_q <= 1'b0;
    end else begin
      pwr_q  <= pwr_d;
      wake_q <= (pwr_q != PWR_RUN) & (pwr_d == PWR_RUN);
    end
  end

  // ==========================================================
  // Event status, set wins over write-one clear

  wire [1:0]   ev_set = {wake_q, tb_end};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_ev
      assign ev_status_d[gi] = ev_set[gi] |
          (ev_status_q[gi] & ~(wr_evs & I_HWDATA[gi]));
    end
  endgenerate

  // Sticky status
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ev_status_q <= 2'h0;
    end else begin
      ev_status_q <= ev_status_d;
    end
  end

  // ==========================================================
  // CPU clock divider

  wire [3:0]   div_last = 4'((5'h02 << cp_sel) - 5'h01);
  wire         cpu_stop = frozen;
  wire         div_wrap = (div_cnt_q >= div_last);
  wire         cpu_en   = ~cpu_stop & (~slow_mode_select | div_wrap);

  // Divider counter
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      div_cnt_q <= 4'h0;
    end else if (~slow_mode_select | div_wrap | cpu_stop) begin
      div_cnt_q <= 4'h0;
    end else begin
      div_cnt_q <= div_cnt_q + 4'h1;
    end
  end

  // ==========================================================
  // Clock out pin

  wire         co_on = clock_out_select & (pwr_q != PWR_AHALT);

  // Toggles on each CPU clock enable while selected
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      clk_out_q      <= 1'b0;
      clk_out_oe_n_q <= 1'b1;
    end else begin
      clk_out_oe_n_q <= ~clock_out_select;
      if (!co_on) begin
        clk_out_q <= 1'b0;
      end else if (cpu_en) begin
        clk_out_q <= ~clk_out_q;
      end
    end
  end

  // ==========================================================
  // Tone generator

  wire [13:0]  tone_last =
      (tone_sel_q == 2'h1) ? 14'(TONE_CYC_1 - 1) :
      (tone_sel_q == 2'h2) ? 14'(TONE_CYC_2 - 1) :
                             14'(TONE_CYC_3 - 1);
  wire         tone_on  = (tone_sel_q != 2'h0) & (pwr_q != PWR_HALT);

  // Square wave, half period per code
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      tone_cnt_q  <= 14'h0000;
      tone_q      <= 1'b0;
      tone_oe_n_q <= 1'b1;
    end else begin
      tone_oe_n_q <= (tone_sel_q == 2'h0);
      if (!tone_on) begin
        tone_cnt_q <= 14'h0000;
        tone_q     <= 1'b0;
      end else if (tone_cnt_q >= tone_last) begin
        tone_cnt_q <= 14'h0000;
        tone_q     <= ~tone_q;
      end else begin
        tone_cnt_q <= tone_cnt_q + 14'h0001;
      end
    end
  end

  // ==========================================================
  // Bus slave, zero wait states

  // Read data is captured at the address phase; writes land a cycle later
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      hrdata_q  <= 32'h00000000;
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
    end else begin
      wr_pend_q <= wr_acc;
      if (wr_acc) begin
        wr_idx_q <= (I_HADDR[31:10] == 22'h000000) ? I_HADDR[9:2] : 8'hFF;
      end
      if (rd_acc) begin
        hrdata_q <= rd_val;
      end
    end
  end

  // ==========================================================
  // Outputs

  assign O_HRDATA       = hrdata_q;
  assign O_HREADYOUT    = 1'b1;
  assign O_HRESP        = 1'b0;
  assign O_PWR_STATE    = pwr_q;
  assign O_WAKE         = wake_q;
  assign O_CPU_CLK_EN   = cpu_en;
  assign O_CLK_OUT      = clk_out_q;
  assign O_CLK_OUT_OE_N = clk_out_oe_n_q;
  assign O_TONE         = tone_q;
  assign O_TONE_OE_N    = tone_oe_n_q;
  assign O_TICK_IRQ_REQ = tick_req;
  assign O_IRQ          = |(ev_status_q & ev_mask_q);

endmodule

`default_nettype wire

// file: verification/mccrt_props.sv
// Concurrent checks on the main clock unit ports
`timescale 1ns/1ps
`default_nettype none
module mccrt_props
  import mccrt_pkg::*;
(
  // Clock, reset and power inputs
  input wire logic       I_MCLK,
  input wire logic       I_RESET_N,
  input wire logic       I_HALT_REQ,
  input wire logic       I_EXT_WAKE,
  input wire logic       I_GLOBAL_MASK,
  // Observed outputs
  input wire logic [3:0] O_PWR_STATE,
  input wire logic       O_WAKE,
  input wire logic       O_CPU_CLK_EN,
  input wire logic       O_CLK_OUT,
  input wire logic       O_CLK_OUT_OE_N,
  input wire logic       O_TONE,
  input wire logic       O_TONE_OE_N,
  input wire logic       O_TICK_IRQ_REQ
);
  // ==========================================================
  // Clocking
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RESET_N);
  // Return to run within two edges of a wake cause
  sequence s_exit;
    ##[1:2] (O_PWR_STATE == PWR_RUN);
  endsequence
  // ==========================================================
  // Properties
  property p_ahalt_clk;
    (O_PWR_STATE == PWR_AHALT) [*2] |-> !O_CLK_OUT;
  endproperty
  property p_oe_clk;
    O_CLK_OUT_OE_N |-> !O_CLK_OUT;
  endproperty
  property p_req_mask;
    I_GLOBAL_MASK |-> !O_TICK_IRQ_REQ;
  endproperty
  property p_halt_enter;
    (O_PWR_STATE == PWR_RUN) && I_HALT_REQ
      |=> O_PWR_STATE inside {PWR_AHALT, PWR_HALT};
  endproperty
  property p_ahalt_wake;
    (O_PWR_STATE == PWR_AHALT) && O_TICK_IRQ_REQ |-> s_exit;
  endproperty
  property p_wait_wake;
    (O_PWR_STATE == PWR_WAIT) && O_TICK_IRQ_REQ |-> s_exit;
  endproperty
  property p_halt_stay;
    (O_PWR_STATE == PWR_HALT) && !I_EXT_WAKE |=> O_PWR_STATE == PWR_HALT;
  endproperty
  property p_halt_wake;
    (O_PWR_STATE == PWR_HALT) && I_EXT_WAKE |-> s_exit;
  endproperty
  property p_sleep_stop;
    O_PWR_STATE inside {PWR_AHALT, PWR_HALT} |-> !O_CPU_CLK_EN;
  endproperty
  property p_tone_off;
    O_TONE_OE_N [*2] |-> !O_TONE;
  endproperty
  property p_wake_pulse;
    $rose(O_WAKE) |=> !O_WAKE;
  endproperty
  // ==========================================================
  // Assertions
  a_ahalt_clk: assert property (p_ahalt_clk)
    else $error("clock out runs in active halt");
  a_oe_clk: assert property (p_oe_clk)
    else $error("clock out toggles while pin released");
  a_req_mask: assert property (p_req_mask)
    else $error("tick request while globally masked");
  a_halt_enter: assert property (p_halt_enter)
    else $error("halt request not taken");
  a_ahalt_wake: assert property (p_ahalt_wake)
    else $error("tick did not end active halt");
  a_wait_wake: assert property (p_wait_wake)
    else $error("tick did not end wait");
  a_halt_stay: assert property (p_halt_stay)
    else $error("halt left without external wake");
  a_halt_wake: assert property (p_halt_wake)
    else $error("external wake did not end halt");
  a_sleep_stop: assert property (p_sleep_stop)
    else $error("cpu clock ticks while halted");
  a_tone_off: assert property (p_tone_off)
    else $error("tone high while pin released");
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("wake pulse longer than one cycle");
endmodule
bind mccrt_top mccrt_props mccrt_props_i (
  .I_MCLK(I_MCLK), .I_RESET_N(I_RESET_N), .I_HALT_REQ(I_HALT_REQ),
  .I_EXT_WAKE(I_EXT_WAKE), .I_GLOBAL_MASK(I_GLOBAL_MASK),
  .O_PWR_STATE(O_PWR_STATE), .O_WAKE(O_WAKE), .O_CPU_CLK_EN(O_CPU_CLK_EN),
  .O_CLK_OUT(O_CLK_OUT), .O_CLK_OUT_OE_N(O_CLK_OUT_OE_N), .O_TONE(O_TONE),
  .O_TONE_OE_N(O_TONE_OE_N), .O_TICK_IRQ_REQ(O_TICK_IRQ_REQ)
);
`default_nettype wire

// file: verification/mccrt_cpu_model.sv
// Behavioural CPU core that puts the unit to sleep and wakes it
`timescale 1ns/1ps
`default_nettype none
module mccrt_cpu_model (
  // Clock
  input  wire logic i_clk,
  // Power and mask requests towards the unit
  output logic      o_wait_req,
  output logic      o_halt_req,
  output logic      o_ext_wake,
  output logic      o_global_mask
);
  // Idle at time zero
  initial begin
    o_wait_req    = 1'b0;
    o_halt_req    = 1'b0;
    o_ext_wake    = 1'b0;
    o_global_mask = 1'b0;
  end
  // One-cycle sleep request, halt or wait
  task automatic sleep(input logic halt);
    o_halt_req <= halt;
    o_wait_req <= !halt;
    @(posedge i_clk);
    o_halt_req <= 1'b0;
    o_wait_req <= 1'b0;
  endtask
  // One-cycle wake from another interrupt source
  task automatic wake();
    o_ext_wake <= 1'b1;
    @(posedge i_clk);
    o_ext_wake <= 1'b0;
  endtask
  // Global interrupt mask level
  task automatic mask(input logic on);
    o_global_mask <= on;
    @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// file: verification/main_clock_rtc_beeper_tb_top.sv
// Self-checking bench for the main clock unit
`timescale 1ns/1ps
`default_nettype none
module main_clock_rtc_beeper_tb_top;
  import mccrt_pkg::*;
  // ==========================================================
  // Addresses and shortened counts
  localparam logic [31:0] A_CCS  = {22'h0, IDX_CLOCK_CONTROL_STATUS, 2'h0};
  localparam logic [31:0] A_TONE = {22'h0, IDX_TONE_CONTROL_REG, 2'h0};
  localparam logic [31:0] A_EVT  = {22'h0, IDX_EVENT_STATUS, 2'h0};
  localparam logic [31:0] A_MASK = {22'h0, IDX_EVENT_MASK, 2'h0};
  logic        clk, rst_n, hsel, hwrite, hready, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, r, v;
  logic        wait_q, halt_q, wake_x, gmask, wake, cpu_en;
  logic        clk_out, clk_oe_n, tone, tone_oe_n, tick, irq, last;
  logic [3:0]  pwr;
  int          cyc, n_mismatch, n_compared, t0, t1, p, n, m;
  int          tbc[4] = '{16, 32, 80, 200};
  int          tnc[4] = '{0, TONE_HALF_1, TONE_HALF_2, TONE_HALF_3};
  // ==========================================================
  // Design, partner and clock
  mccrt_top #(.TB_CYC_0(16), .TB_CYC_1(32), .TB_CYC_2(80),
    .TB_CYC_3(200)) mccrt_top_i (
    .I_MCLK(clk), .I_RESET_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
    .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
    .O_HREADYOUT(hready), .O_HRESP(hresp), .I_WAIT_REQ(wait_q),
    .I_HALT_REQ(halt_q), .I_EXT_WAKE(wake_x), .I_GLOBAL_MASK(gmask),
    .O_PWR_STATE(pwr), .O_WAKE(wake), .O_CPU_CLK_EN(cpu_en),
    .O_CLK_OUT(clk_out), .O_CLK_OUT_OE_N(clk_oe_n), .O_TONE(tone),
    .O_TONE_OE_N(tone_oe_n), .O_TICK_IRQ_REQ(tick), .O_IRQ(irq));
  mccrt_cpu_model mccrt_cpu_model_i (.i_clk(clk), .o_wait_req(wait_q),
    .o_halt_req(halt_q), .o_ext_wake(wake_x), .o_global_mask(gmask));
  always #2.5 clk = ~clk;
  // Cycle count for period measurements
  always @(posedge clk) cyc <= cyc + 1;
  // ==========================================================
  // Shared tasks
  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  // Single AHB-Lite transfer; whole word only
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    check(hresp === 1'b0, "error response");
  endtask
  task automatic wait_tick(output int t);
    do @(posedge clk); while (tick !== 1'b1);
    t = cyc;
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Watchdog: about twice the run, which the full tone half periods dominate
  initial begin
    #(5 * 60000);
    n_mismatch++;
    finish_test();
  end
  // ==========================================================
  // Test sequence
  initial begin
    clk    = 1'b0;
    rst_n  = 1'b0;
    hsel   = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize  = 3'h2;
    haddr  = 32'h0;
    hwdata = 32'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, A_CCS, 0, r);
    check(r === 32'h0, "status reset value");
    bus(0, 32'h100, 0, r);
    check(r === 32'h0, "unmapped read");
    $display("test reset done");
    // Periods, deferred select change, set and read clear of the flag
    bus(1, A_CCS, 32'h2, r);
    wait_tick(t0);
    p = 0;
    for (int c = 0; c < 4; c++) begin
      bus(0, A_CCS, 0, r);
      check(r[7:0] === 8'(p * 4 + 3), "flag not set");
      bus(0, A_CCS, 0, r);
      check(r[0] === 1'b0, "flag not cleared by read");
      bus(1, A_CCS, 32'(c * 4 + 2), r);
      wait_tick(t1);
      check(t1 - t0 == tbc[p], "old period not kept");
      t0 = t1;
      bus(0, A_CCS, 0, r);
      wait_tick(t1);
      check(t1 - t0 == tbc[c], "period wrong");
      t0 = t1;
      p = c;
    end
    $display("test time base done");
    // Event interrupt and global mask
    check(irq === 1'b0, "irq while masked");
    bus(1, A_MASK, 32'h1, r);
    @(posedge clk);
    check(irq === 1'b1, "irq not raised");
    bus(1, A_EVT, 32'h1, r);
    @(posedge clk);
    check(irq === 1'b0, "irq not cleared");
    bus(1, A_MASK, 32'h0, r);
    mccrt_cpu_model_i.mask(1'b1);
    check(tick === 1'b0, "request under mask");
    mccrt_cpu_model_i.mask(1'b0);
    @(posedge clk);
    check(tick === 1'b1, "request lost");
    $display("test interrupt done");
    // Active halt, wait and halt
    bus(1, A_CCS, 32'h8E, r);
    bus(0, A_CCS, 0, r);
    mccrt_cpu_model_i.sleep(1'b1);
    @(posedge clk);
    check(pwr === PWR_AHALT, "no active halt");
    bus(1, A_CCS, 32'h0, r);
    wait_tick(t1);
    repeat (3) @(posedge clk);
    check(pwr === PWR_RUN, "tick did not wake");
    bus(0, A_CCS, 0, r);
    check(r[7:0] === 8'h8F, "registers not frozen");
    mccrt_cpu_model_i.sleep(1'b0);
    @(posedge clk);
    check(pwr === PWR_WAIT && cpu_en === 1'b1, "wait");
    wait_tick(t1);
    repeat (3) @(posedge clk);
    check(pwr === PWR_RUN, "tick did not end wait");
    bus(1, A_EVT, 32'h2, r);
    bus(1, A_CCS, 32'hC, r);
    mccrt_cpu_model_i.sleep(1'b1);
    repeat (250) @(posedge clk);
    check(pwr === PWR_HALT, "halt not held");
    bus(0, A_EVT, 0, r);
    check(r[1] === 1'b0, "wake event before wake");
    mccrt_cpu_model_i.wake();
    repeat (3) @(posedge clk);
    check(pwr === PWR_RUN, "halt not ended");
    bus(0, A_EVT, 0, r);
    check(r[1] === 1'b1, "wake event not recorded");
    $display("test power done");
    // CPU clock divider and clock out
    for (int d = 0; d < 5; d++) begin
      v = (d < 4) ? 32'h90 + 32'(d) * 32'h20 : 32'h80;
      bus(1, v, 0, r);
      bus(1, A_CCS, v, r);
      repeat (16) @(posedge clk);
      n = 0;
      m = 0;
      last = clk_out;
      repeat (64) begin
        @(posedge clk);
        n += int'(cpu_en === 1'b1);
        m += int'(clk_out !== last);
        last = clk_out;
      end
      check(n == ((d < 4) ? 64 >> (d + 1) : 64), "cpu rate");
      check(m == n && clk_oe_n === 1'b0, "clock out");
    end
    bus(1, A_CCS, 32'h0, r);
    repeat (2) @(posedge clk);
    check(clk_oe_n === 1'b1, "clock out pin kept");
    $display("test divider done");
    // Tone half periods and off code
    for (int c = 1; c < 4; c++) begin
      bus(1, A_TONE, 32'(c), r);
      last = tone;
      do @(posedge clk); while (tone === last);
      t0 = cyc;
      last = tone;
      do @(posedge clk); while (tone === last);
      check(cyc - t0 == tnc[c], "tone period");
      check(tone_oe_n === 1'b0, "tone pin off");
    end
    bus(1, A_TONE, 32'h0, r);
    repeat (2) @(posedge clk);
    check(tone_oe_n === 1'b1 && tone === 1'b0, "tone not off");
    $display("test tone done");
    finish_test();
  end
endmodule
`default_nettype wire
